// >>> test/pcs_host_model.sv
`timescale 1ns/10ps
module pcs_host_model (
	input wire logic core_clk_i,
	input wire logic pdo_i,
	output logic pclk_o,
	output logic pdi_o,
	output logic psel_n_o
);
	initial begin
		pclk_o = 1'b0;
		pdi_o = 1'b0;
		psel_n_o = 1'b1;
	end
	// one frame: address msb first, direction, data msb first
	task automatic xfer(input logic [6:0] a, input logic w,
		input logic [7:0] wd, output logic [7:0] rd);
		logic [15:0] f;
		f = {a, w, wd};
		rd = 8'h00;
		@(posedge core_clk_i);
		psel_n_o <= 1'b0;
		repeat (2) @(posedge core_clk_i);
		for (int i = 15; i >= 0; i--) begin
			pclk_o <= 1'b0;
			pdi_o <= f[i];
			repeat (3) @(posedge core_clk_i);
			if (i < 8) begin
				rd[i] = pdo_i;
			end
			pclk_o <= 1'b1;
			repeat (3) @(posedge core_clk_i);
		end
		repeat (4) @(posedge core_clk_i);
		psel_n_o <= 1'b1;
		pclk_o <= 1'b0;
		pdi_o <= ~f[0];
		repeat (3) @(posedge core_clk_i);
	endtask
endmodule

// >>> test/pcs_regs_asserts.sv
`timescale 1ns/10ps
module pcs_regs_asserts
	import pcs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic psel_n_i,
	input wire logic pdo_o,
	input wire logic pdo_oe_o,
	input wire logic cal_start_i,
	input wire logic [1:0] step_wait_select_o,
	input wire logic [1:0] vco_current_wait_select_o,
	input wire logic [3:0] comparator_decision_limit_o,
	input wire logic cal_busy_o,
	input wire logic cal_complete_o,
	input wire logic cal_step_strobe_o,
	input wire logic [1:0] cal_step_o
);
	// ------------------------------------------------
	// cycles since last step strobe
	// ------------------------------------------------
	logic [7:0] gap_q, gap_d, step_gap, cur_gap;
	always_comb begin
		gap_d = cal_step_strobe_o ? 8'h01 : gap_q + {7'h00, gap_q != 8'hff};
		step_gap = 8'h01 + (step_wait_select_o == 2'h0 ? 8'h01 :
			step_wait_select_o == 2'h1 ? 8'h02 :
			step_wait_select_o == 2'h2 ? 8'h06 : 8'h32);
		cur_gap = 8'h01 + (vco_current_wait_select_o == 2'h0 ? 8'h01 :
			vco_current_wait_select_o == 2'h1 ? 8'h0c :
			vco_current_wait_select_o == 2'h2 ? 8'h3f : 8'h7f);
	end
	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			gap_q <= 8'h00;
		end else begin
			gap_q <= gap_d;
		end
	end
	// ------------------------------------------------
	// properties
	// ------------------------------------------------
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_step(logic [1:0] n);
		cal_step_strobe_o && cal_step_o == n;
	endsequence
	AST_START_BUSY: assert property (cal_start_i && !cal_busy_o |=>
		cal_busy_o && !cal_complete_o) else $error("start not taken");
	AST_BUSY_CAUSE: assert property ($rose(cal_busy_o) |->
		$past(cal_start_i)) else $error("busy without start");
	AST_LAST_DONE: assert property (s_step(2'h3) |-> ##[0:1]
		cal_complete_o) else $error("complete missing");
	AST_FALL_DONE: assert property ($fell(cal_busy_o) |->
		cal_complete_o) else $error("busy ended early");
	AST_ORDER_01: assert property (s_step(2'h0) |-> ##[2:52]
		s_step(2'h1)) else $error("array step missing");
	AST_ORDER_23: assert property (s_step(2'h2) |-> ##[2:129]
		s_step(2'h3)) else $error("current step missing");
	AST_GAP_STEP: assert property (cal_step_strobe_o &&
		cal_step_o inside {2'h1, 2'h2} |-> gap_q == step_gap)
		else $error("step wait wrong");
	AST_GAP_CUR: assert property (s_step(2'h3) |->
		gap_q == cur_gap) else $error("current wait wrong");
	AST_SEL_WRITE: assert property ($changed({step_wait_select_o,
		vco_current_wait_select_o, comparator_decision_limit_o}) |->
		$past(psel_n_i, 2) == 1'b0) else $error("timing changed idle");
	AST_OE_RELEASE: assert property (psel_n_i |=> !pdo_oe_o)
		else $error("output enable held after deselect");
	AST_PDO_QUIET: assert property (!pdo_oe_o |-> !pdo_o)
		else $error("data out not quiet");
	AST_STROBE_ONE: assert property (cal_step_strobe_o |=>
		!cal_step_strobe_o) else $error("strobe too long");
endmodule

bind pcs_regs pcs_regs_asserts u_chk (.core_clk_i(core_clk_i),
	.rstn_i(rstn_i), .psel_n_i(psel_n_i), .cal_start_i(cal_start_i),
	.pdo_o(pdo_o), .pdo_oe_o(pdo_oe_o),
	.step_wait_select_o(step_wait_select_o),
	.vco_current_wait_select_o(vco_current_wait_select_o),
	.comparator_decision_limit_o(comparator_decision_limit_o),
	.cal_busy_o(cal_busy_o), .cal_complete_o(cal_complete_o),
	.cal_step_strobe_o(cal_step_strobe_o), .cal_step_o(cal_step_o));

// >>> test/tb_pcs_regs.sv
`timescale 1ns/10ps
module tb_pcs_regs
	import pcs_pkg::*;
;
	localparam logic [2:0] REV = 3'h6; // arbitrary value
	logic core_clk_i = 1'b0, rstn_i = 1'b0, cal_start_i = 1'b0;
	logic [4:0] st = 5'h00, rf = 5'h00, arr = 5'h00;
	logic [3:0] dac = 4'h0, chp = 4'h0, lim;
	logic fc = 1'b0, fce = 1'b0, vcc = 1'b0;
	logic [5:0] vcur = 6'h00;
	logic pclk, pdi, psel_n, pdo, busy, done, stb;
	logic [1:0] sws, cws, step;
	int error_cnt = 0, total_checks = 0;
	always #25 core_clk_i = ~core_clk_i;

	pcs_regs #(.SILICON_REVISION(REV)) DUT (.core_clk_i(core_clk_i),
		.rstn_i(rstn_i), .pclk_i(pclk), .pdi_i(pdi), .psel_n_i(psel_n),
		.pdo_o(pdo), .pdo_oe_o(), .cal_start_i(cal_start_i),
		.pll_lock_now_i(st[4]), .pll_lock_qualified_i(st[3]),
		.lock_pin_i(st[2]), .data_clock_pin_i(st[1]),
		.data_io_pin_i(st[0]), .shaping_filter_cleared_i(rf[4]),
		.prbs_cleared_i(rf[3]), .synth_digital_cleared_i(rf[2]),
		.cal_logic_cleared_i(rf[1]), .lock_det_cleared_i(rf[0]),
		.cal_dac_i(dac), .chp_current_i(chp), .vco_array_i(arr),
		.freq_comp_i(fc), .freq_comp_enable_i(fce), .vco_cal_comp_i(vcc),
		.vco_cal_current_i(vcur), .step_wait_select_o(sws),
		.vco_current_wait_select_o(cws),
		.comparator_decision_limit_o(lim), .cal_busy_o(busy),
		.cal_complete_o(done), .cal_step_strobe_o(stb), .cal_step_o(step));
	pcs_host_model u_host (.core_clk_i(core_clk_i), .pdo_i(pdo),
		.pclk_o(pclk), .pdi_o(pdi), .psel_n_o(psel_n));

	// ------------------------------------------------
	// helpers
	// ------------------------------------------------
	task automatic chk(input string nm, input logic [7:0] e,
		input logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			error_cnt++;
			$display("mismatch %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		u_host.xfer(a, 1'b0, 8'h00, d);
	endtask
	task automatic wr(input logic [6:0] a, input logic [7:0] v);
		logic [7:0] d;
		u_host.xfer(a, 1'b1, v, d);
	endtask
	task automatic summarize();
		$display("checks %0d mismatches %0d", total_checks, error_cnt);
		if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------
	// scenarios
	// ------------------------------------------------
	task automatic t_timing();
		logic [7:0] d;
		rd(ADDR_CAL_TIMING, d);
		chk("timing reset", 8'h15, d);
		chk("fields reset", 8'h15, {sws, cws, lim});
		wr(ADDR_CAL_TIMING, 8'hb9);
		rd(ADDR_CAL_TIMING, d);
		chk("timing back", 8'hb9, d);
		chk("fields", 8'hb9, {sws, cws, lim});
		$display("test timing done");
	endtask
	task automatic t_status();
		logic [7:0] d;
		logic [4:0] p[4] = '{5'h15, 5'h0a, 5'h13, 5'h0c};
		for (int i = 0; i < 4; i++) begin
			@(posedge core_clk_i);
			st <= p[i];
			rf <= {p[i][4:2], p[i][1], ~p[i][0]};
			wr(ADDR_PLL_STATUS, 8'hff);
			rd(ADDR_PLL_STATUS, d);
			chk("status", {2'b00, p[i][4:3], 1'b0, p[i][2:0]}, d);
			rd(ADDR_RESET_FLAGS, d);
			chk("flags", {2'b00, p[i][4], 1'b0, p[i][3:2], 1'b0,
				p[i][1] & ~p[i][0]}, d);
		end
		chk("timing kept", 8'hb9, {sws, cws, lim});
		$display("test status done");
	endtask
	task automatic t_readback();
		logic [7:0] d;
		@(posedge core_clk_i);
		{dac, chp, arr, fc, vcc, vcur} <= {8'ha3, 5'h16, 2'b11, 6'h2d};
		rd(ADDR_DAC_CHP, d);
		chk("dac chp", 8'ha3, d);
		rd(ADDR_REV_ARRAY, d);
		chk("rev array", {REV, 5'h16}, d);
		rd(ADDR_VCO_CUR, d);
		chk("vco cur off", 8'h6d, d);
		fce <= 1'b1;
		rd(ADDR_VCO_CUR, d);
		chk("vco cur on", 8'hed, d);
		{fc, vcc} <= 2'b00;
		rd(ADDR_VCO_CUR, d);
		chk("vco cur low", 8'h2d, d);
		rd(7'h30, d);
		chk("unmapped", 8'h00, d);
		$display("test readback done");
	endtask
	task automatic t_cal();
		int sw[4] = '{1, 2, 6, 50};
		int cw[4] = '{1, 12, 63, 127};
		int t[8];
		logic [1:0] s[8];
		int k;
		logic [7:0] d;
		for (int c = 0; c < 4; c++) begin
			wr(ADDR_CAL_TIMING, {c[1:0], c[1:0], 4'h5});
			@(posedge core_clk_i);
			cal_start_i <= 1'b1;
			@(posedge core_clk_i);
			@(posedge core_clk_i);
			cal_start_i <= 1'b0;
			chk("busy", 8'h01, {7'h0, busy});
			chk("complete low", 8'h00, {7'h0, done});
			k = 0;
			for (int n = 0; n < 400; n++) begin
				@(posedge core_clk_i);
				if (stb === 1'b1 && k < 8) begin
					t[k] = n;
					s[k] = step;
					k++;
				end
			end
			if (k < 4) begin
				error_cnt++;
				$display("mismatch strobes expected 4 seen %0d", k);
				summarize();
			end
			chk("strobes", 8'h04, k[7:0]);
			for (int i = 0; i < 4; i++) chk("order", i[7:0], {6'h0, s[i]});
			chk("dac wait", 8'(sw[c]), 8'(t[0]));
			chk("step wait", 8'(sw[c] + 1), 8'(t[1] - t[0]));
			chk("chp wait", 8'(sw[c] + 1), 8'(t[2] - t[1]));
			chk("cur wait", 8'(cw[c] + 1), 8'(t[3] - t[2]));
			chk("idle", 8'h00, {7'h0, busy});
			rd(ADDR_PLL_STATUS, d);
			chk("complete", 8'h80, d & 8'h80);
		end
		$display("test calibration done");
	endtask

	initial begin
		repeat (6) @(posedge core_clk_i);
		rstn_i <= 1'b1;
		repeat (2) @(posedge core_clk_i);
		t_timing();
		t_status();
		t_readback();
		t_cal();
		summarize();
	end
endmodule

// >>> verilog/pcs_cfg_serial.sv
`timescale 1ns/10ps
module pcs_cfg_serial
	import pcs_pkg::*;
(
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic pclk_i,
	input wire logic pdi_i,
	input wire logic psel_n_i,
	input wire logic [7:0] rd_data_i,
	output logic [6:0] addr_o,
	output logic wr_stb_o,
	output logic [7:0] wr_data_o,
	output logic pdo_o,
	output logic pdo_oe_o
);

	logic pclk_q;
	logic [4:0] bit_q, bit_d;
	logic [7:0] sh_q, sh_d;
	logic [6:0] addr_q, addr_d;
	logic dir_q, dir_d;
	logic wr_q, wr_d;
	logic [7:0] wdat_q, wdat_d;
	logic [7:0] out_q, out_d;
	logic pdo_q, pdo_d;
	logic oe_q, oe_d;
	logic rise, fall;

	assign rise = pclk_i & ~pclk_q;
	assign fall = ~pclk_i & pclk_q;

	// ----------------------------------------------------------------
	// frame decode: sample on rising edge, shift out on falling edge
	// ----------------------------------------------------------------
	always_comb begin
		bit_d = bit_q;
		sh_d = sh_q;
		addr_d = addr_q;
		dir_d = dir_q;
		wr_d = 1'b0;
		wdat_d = wdat_q;
		out_d = out_q;
		pdo_d = pdo_q;
		oe_d = oe_q;
		if (psel_n_i) begin
			bit_d = '0;
			oe_d = 1'b0;
			pdo_d = 1'b0;
		end else if (rise && bit_q != SER_FRAME_END) begin
			sh_d = {sh_q[6:0], pdi_i};
			bit_d = bit_q + 5'h01;
			if (bit_q == SER_DIR_BIT - 5'h01)
				addr_d = {sh_q[5:0], pdi_i};
			if (bit_q == SER_DIR_BIT)
				dir_d = pdi_i;
			if (bit_q == SER_LAST_BIT && dir_q == SER_WRITE) begin
				wr_d = 1'b1;
				wdat_d = {sh_q[6:0], pdi_i};
			end
		end else if (fall && dir_q != SER_WRITE) begin
			if (bit_q == SER_DATA_BIT && !oe_q) begin
				out_d = rd_data_i;
				pdo_d = rd_data_i[7];
				oe_d = 1'b1;
			end else if (oe_q && bit_q != SER_FRAME_END) begin
				out_d = {out_q[6:0], 1'b0};
				pdo_d = out_q[6];
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pclk_q <= 1'b0;
			bit_q <= '0;
			sh_q <= '0;
			addr_q <= '0;
			dir_q <= 1'b0;
			wr_q <= 1'b0;
			wdat_q <= '0;
			out_q <= '0;
			pdo_q <= 1'b0;
			oe_q <= 1'b0;
		end else begin
			pclk_q <= pclk_i;
			bit_q <= bit_d;
			sh_q <= sh_d;
			addr_q <= addr_d;
			dir_q <= dir_d;
			wr_q <= wr_d;
			wdat_q <= wdat_d;
			out_q <= out_d;
			pdo_q <= pdo_d;
			oe_q <= oe_d;
		end
	end

	assign addr_o = addr_q;
	assign wr_stb_o = wr_q;
	assign wr_data_o = wdat_q;
	assign pdo_o = pdo_q;
	assign pdo_oe_o = oe_q;

endmodule

// >>> verilog/pcs_pkg.sv
package pcs_pkg;

	// ----------------------------------------------------------------
	// register addresses on the serial configuration port
	// ----------------------------------------------------------------
	localparam int ADDR_W = 7;
	localparam logic [6:0] ADDR_CAL_TIMING = 7'h28;
	localparam logic [6:0] ADDR_PLL_STATUS = 7'h40;
	localparam logic [6:0] ADDR_RESET_FLAGS = 7'h41;
	localparam logic [6:0] ADDR_DAC_CHP = 7'h45;
	localparam logic [6:0] ADDR_REV_ARRAY = 7'h46;
	localparam logic [6:0] ADDR_VCO_CUR = 7'h47;

	// ----------------------------------------------------------------
	// calibration timing fields and reset values
	// ----------------------------------------------------------------
	localparam int TIM_STEP_MSB = 7;
	localparam int TIM_STEP_LSB = 6;
	localparam int TIM_CUR_MSB = 5;
	localparam int TIM_CUR_LSB = 4;
	localparam int TIM_LIM_MSB = 3;
	localparam int TIM_LIM_LSB = 0;
	localparam logic [1:0] STEP_WAIT_RST = 2'h0;
	localparam logic [1:0] CUR_WAIT_RST = 2'h1;
	localparam logic [3:0] DEC_LIMIT_RST = 4'h5;

	// ----------------------------------------------------------------
	// wait counts in core clock cycles, indexed by select code
	// ----------------------------------------------------------------
	localparam int WAIT_W = 7;
	localparam logic [6:0] STEP_WAIT_C0 = 7'h01;
	localparam logic [6:0] STEP_WAIT_C1 = 7'h02;
	localparam logic [6:0] STEP_WAIT_C2 = 7'h06;
	localparam logic [6:0] STEP_WAIT_C3 = 7'h32;
	localparam logic [6:0] CUR_WAIT_C0 = 7'h01;
	localparam logic [6:0] CUR_WAIT_C1 = 7'h0c;
	localparam logic [6:0] CUR_WAIT_C2 = 7'h3f;
	localparam logic [6:0] CUR_WAIT_C3 = 7'h7f;

	// ----------------------------------------------------------------
	// status bit positions
	// ----------------------------------------------------------------
	localparam int ST_CAL_DONE = 7;
	localparam int ST_LOCK_NOW = 5;
	localparam int ST_LOCK_QUAL = 4;
	localparam int ST_LOCK_PIN = 2;
	localparam int ST_DATA_CLOCK_PIN = 1;
	localparam int ST_DIO = 0;
	localparam int RF_SHAPE = 5;
	localparam int RF_PRBS = 3;
	localparam int RF_SYNTH = 2;
	localparam int RF_CAL_LOCK = 0;
	localparam int VC_FCOMP = 7;
	localparam int VC_CMP = 6;

	// ----------------------------------------------------------------
	// serial frame layout: 7 address bits, direction bit, 8 data bits
	// ----------------------------------------------------------------
	localparam logic [4:0] SER_DIR_BIT = 5'h07;
	localparam logic [4:0] SER_DATA_BIT = 5'h08;
	localparam logic [4:0] SER_LAST_BIT = 5'h0f;
	localparam logic [4:0] SER_FRAME_END = 5'h10;
	localparam logic SER_WRITE = 1'b1;

	typedef enum logic [2:0] {
		CAL_IDLE = 3'b000,
		CAL_DAC = 3'b001,
		CAL_ARRAY = 3'b010,
		CAL_CHP = 3'b011,
		CAL_CUR = 3'b100
	} pcs_cal_state_t;

	typedef enum logic [1:0] {
		STEP_DAC = 2'b00,
		STEP_ARRAY = 2'b01,
		STEP_CHP = 2'b10,
		STEP_CUR = 2'b11
	} pcs_cal_step_t;

endpackage

// >>> verilog/pcs_regs.sv
`timescale 1ns/10ps
module pcs_regs
	import pcs_pkg::*;
#(
	// arbitrary value, not a real part code
	parameter logic [2:0] SILICON_REVISION = 3'h5
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic pclk_i,
	input wire logic pdi_i,
	input wire logic psel_n_i,
	output logic pdo_o,
	output logic pdo_oe_o,
	input wire logic cal_start_i,
	input wire logic pll_lock_now_i,
	input wire logic pll_lock_qualified_i,
	input wire logic lock_pin_i,
	input wire logic data_clock_pin_i,
	input wire logic data_io_pin_i,
	input wire logic shaping_filter_cleared_i,
	input wire logic prbs_cleared_i,
	input wire logic synth_digital_cleared_i,
	input wire logic cal_logic_cleared_i,
	input wire logic lock_det_cleared_i,
	input wire logic [3:0] cal_dac_i,
	input wire logic [3:0] chp_current_i,
	input wire logic [4:0] vco_array_i,
	input wire logic freq_comp_i,
	input wire logic freq_comp_enable_i,
	input wire logic vco_cal_comp_i,
	input wire logic [5:0] vco_cal_current_i,
	output logic [1:0] step_wait_select_o,
	output logic [1:0] vco_current_wait_select_o,
	output logic [3:0] comparator_decision_limit_o,
	output logic cal_busy_o,
	output logic cal_complete_o,
	output logic cal_step_strobe_o,
	output logic [1:0] cal_step_o
);

	// ----------------------------------------------------------------
	// serial port and register storage
	// ----------------------------------------------------------------
	logic [6:0] ser_addr;
	logic ser_wr;
	logic [7:0] ser_wdata;
	logic [7:0] rd_data;

	logic [1:0] step_sel_q, step_sel_d;
	logic [1:0] cur_sel_q, cur_sel_d;
	logic [3:0] dec_lim_q, dec_lim_d;

	logic [7:0] pll_status_q, pll_status_d;
	logic [7:0] reset_flags_q, reset_flags_d;
	logic [7:0] dac_chp_q, dac_chp_d;
	logic [7:0] rev_array_q, rev_array_d;
	logic [7:0] vco_cur_q, vco_cur_d;

	pcs_cal_state_t cal_q, cal_d;
	logic done_flag_q, done_flag_d;
	logic strobe_q, strobe_d;
	logic [1:0] step_q, step_d;
	logic busy_q, busy_d;

	logic tmr_start;
	logic [6:0] tmr_cycles;
	logic tmr_done;
	logic [6:0] step_wait;
	logic [6:0] cur_wait;
	logic cal_lock_done;
	logic fcomp_gated;

	// ----------------------------------------------------------------
	// serial configuration port
	// ----------------------------------------------------------------
	pcs_cfg_serial u_serial (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.pclk_i(pclk_i),
		.pdi_i(pdi_i),
		.psel_n_i(psel_n_i),
		.rd_data_i(rd_data),
		.addr_o(ser_addr),
		.wr_stb_o(ser_wr),
		.wr_data_o(ser_wdata),
		.pdo_o(pdo_o),
		.pdo_oe_o(pdo_oe_o)
	);

	// ----------------------------------------------------------------
	// calibration timing register
	// ----------------------------------------------------------------
	always_comb begin
		step_sel_d = step_sel_q;
		cur_sel_d = cur_sel_q;
		dec_lim_d = dec_lim_q;
		if (ser_wr && ser_addr == ADDR_CAL_TIMING) begin
			step_sel_d = ser_wdata[TIM_STEP_MSB:TIM_STEP_LSB];
			cur_sel_d = ser_wdata[TIM_CUR_MSB:TIM_CUR_LSB];
			dec_lim_d = ser_wdata[TIM_LIM_MSB:TIM_LIM_LSB];
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			step_sel_q <= STEP_WAIT_RST;
			cur_sel_q <= CUR_WAIT_RST;
			dec_lim_q <= DEC_LIMIT_RST;
		end else begin
			step_sel_q <= step_sel_d;
			cur_sel_q <= cur_sel_d;
			dec_lim_q <= dec_lim_d;
		end
	end

	// ----------------------------------------------------------------
	// wait length lookup
	// ----------------------------------------------------------------
	always_comb begin
		case (step_sel_q)
			2'h0: step_wait = STEP_WAIT_C0;
			2'h1: step_wait = STEP_WAIT_C1;
			2'h2: step_wait = STEP_WAIT_C2;
			2'h3: step_wait = STEP_WAIT_C3;
			default: step_wait = STEP_WAIT_C0;
		endcase
		case (cur_sel_q)
			2'h0: cur_wait = CUR_WAIT_C0;
			2'h1: cur_wait = CUR_WAIT_C1;
			2'h2: cur_wait = CUR_WAIT_C2;
			2'h3: cur_wait = CUR_WAIT_C3;
			default: cur_wait = CUR_WAIT_C1;
		endcase
	end

	// ----------------------------------------------------------------
	// step wait timer
	// ----------------------------------------------------------------
	pcs_wait_timer #(
		.CNT_W(WAIT_W)
	) u_timer (
		.core_clk_i(core_clk_i),
		.rstn_i(rstn_i),
		.start_i(tmr_start),
		.cycles_i(tmr_cycles),
		.done_o(tmr_done)
	);

	// ----------------------------------------------------------------
	// calibration sequencer
	// ----------------------------------------------------------------
	always_comb begin
		cal_d = cal_q;
		done_flag_d = done_flag_q;
		strobe_d = 1'b0;
		step_d = step_q;
		busy_d = busy_q;
		tmr_start = 1'b0;
		tmr_cycles = step_wait;
		case (cal_q)
			CAL_IDLE: begin
				if (cal_start_i) begin
					done_flag_d = 1'b0;
					busy_d = 1'b1;
					tmr_start = 1'b1;
					cal_d = CAL_DAC;
				end
			end
			CAL_DAC: begin
				if (tmr_done) begin
					strobe_d = 1'b1;
					step_d = STEP_DAC;
					tmr_start = 1'b1;
					cal_d = CAL_ARRAY;
				end
			end
			CAL_ARRAY: begin
				if (tmr_done) begin
					strobe_d = 1'b1;
					step_d = STEP_ARRAY;
					tmr_start = 1'b1;
					cal_d = CAL_CHP;
				end
			end
			CAL_CHP: begin
				if (tmr_done) begin
					strobe_d = 1'b1;
					step_d = STEP_CHP;
					tmr_start = 1'b1;
					tmr_cycles = cur_wait;
					cal_d = CAL_CUR;
				end
			end
			CAL_CUR: begin
				if (tmr_done) begin
					strobe_d = 1'b1;
					step_d = STEP_CUR;
					busy_d = 1'b0;
					done_flag_d = 1'b1;
					cal_d = CAL_IDLE;
				end
			end
			default: begin
				cal_d = CAL_IDLE;
				busy_d = 1'b0;
			end
		endcase
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cal_q <= CAL_IDLE;
			done_flag_q <= 1'b0;
			strobe_q <= 1'b0;
			step_q <= STEP_DAC;
			busy_q <= 1'b0;
		end else begin
			cal_q <= cal_d;
			done_flag_q <= done_flag_d;
			strobe_q <= strobe_d;
			step_q <= step_d;
			busy_q <= busy_d;
		end
	end

	// ----------------------------------------------------------------
	// combined readback terms
	// ----------------------------------------------------------------
	// both resets finished
	assign cal_lock_done = cal_logic_cleared_i & lock_det_cleared_i;
	assign fcomp_gated = freq_comp_i & freq_comp_enable_i;

	// ----------------------------------------------------------------
	// status capture, refreshed every cycle
	// ----------------------------------------------------------------
	always_comb begin
		pll_status_d = '0;
		reset_flags_d = '0;
		pll_status_d[ST_CAL_DONE] = done_flag_d;
		pll_status_d[ST_LOCK_NOW] = pll_lock_now_i;
		pll_status_d[ST_LOCK_QUAL] = pll_lock_qualified_i;
		pll_status_d[ST_LOCK_PIN] = lock_pin_i;
		pll_status_d[ST_DATA_CLOCK_PIN] = data_clock_pin_i;
		pll_status_d[ST_DIO] = data_io_pin_i;
		reset_flags_d[RF_SHAPE] = shaping_filter_cleared_i;
		reset_flags_d[RF_PRBS] = prbs_cleared_i;
		reset_flags_d[RF_SYNTH] = synth_digital_cleared_i;
		reset_flags_d[RF_CAL_LOCK] = cal_lock_done;
		dac_chp_d = {cal_dac_i, chp_current_i};
		rev_array_d = {SILICON_REVISION, vco_array_i};
		vco_cur_d = '0;
		vco_cur_d[VC_FCOMP] = fcomp_gated;
		vco_cur_d[VC_CMP] = vco_cal_comp_i;
		vco_cur_d[VC_CMP-1:0] = vco_cal_current_i;
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			pll_status_q <= '0;
			reset_flags_q <= '0;
			dac_chp_q <= '0;
			rev_array_q <= '0;
			vco_cur_q <= '0;
		end else begin
			pll_status_q <= pll_status_d;
			reset_flags_q <= reset_flags_d;
			dac_chp_q <= dac_chp_d;
			rev_array_q <= rev_array_d;
			vco_cur_q <= vco_cur_d;
		end
	end

	// ----------------------------------------------------------------
	// read mux, writes to status addresses have no decode
	// ----------------------------------------------------------------
	always_comb begin
		case (ser_addr)
			ADDR_CAL_TIMING: rd_data = {step_sel_q, cur_sel_q, dec_lim_q};
			ADDR_PLL_STATUS: rd_data = pll_status_q;
			ADDR_RESET_FLAGS: rd_data = reset_flags_q;
			ADDR_DAC_CHP: rd_data = dac_chp_q;
			ADDR_REV_ARRAY: rd_data = rev_array_q;
			ADDR_VCO_CUR: rd_data = vco_cur_q;
			default: rd_data = '0;
		endcase
	end

	// ----------------------------------------------------------------
	// registered outputs
	// ----------------------------------------------------------------
	assign step_wait_select_o = step_sel_q;
	assign vco_current_wait_select_o = cur_sel_q;
	assign comparator_decision_limit_o = dec_lim_q;
	assign cal_busy_o = busy_q;
	assign cal_complete_o = done_flag_q;
	assign cal_step_strobe_o = strobe_q;
	assign cal_step_o = step_q;

endmodule

// >>> verilog/pcs_wait_timer.sv
`timescale 1ns/10ps
module pcs_wait_timer
	import pcs_pkg::*;
#(
	parameter int CNT_W = WAIT_W
) (
	input wire logic core_clk_i,
	input wire logic rstn_i,
	input wire logic start_i,
	input wire logic [CNT_W-1:0] cycles_i,
	output logic done_o
);

	logic [CNT_W-1:0] cnt_q, cnt_d;
	logic busy_q, busy_d;
	logic done_q, done_d;

	// ----------------------------------------------------------------
	// down counter, one done pulse when the wait runs out
	// ----------------------------------------------------------------
	always_comb begin
		cnt_d = cnt_q;
		busy_d = busy_q;
		done_d = 1'b0;
		if (start_i) begin
			cnt_d = cycles_i;
			busy_d = 1'b1;
		end else if (busy_q) begin
			cnt_d = cnt_q - {{(CNT_W-1){1'b0}}, 1'b1};
			if (cnt_q <= {{(CNT_W-1){1'b0}}, 1'b1}) begin
				busy_d = 1'b0;
				done_d = 1'b1;
			end
		end
	end

	always_ff @(posedge core_clk_i or negedge rstn_i) begin
		if (!rstn_i) begin
			cnt_q <= '0;
			busy_q <= 1'b0;
			done_q <= 1'b0;
		end else begin
			cnt_q <= cnt_d;
			busy_q <= busy_d;
			done_q <= done_d;
		end
	end

	assign done_o = done_q;

endmodule
